/* File: rtl/dpr_pkg.sv */
// package: constants shared by the dual-port memory and its port logic
package dpr_pkg;
	localparam int ADDR_W = 15;
	localparam int DATA_W = 8;
	localparam int DEPTH = 32768;
	localparam logic [14:0] ADDR_ZERO = 15'h0000;
	localparam logic [14:0] ADDR_ONE = 15'h0001;
	localparam logic [7:0] DATA_RST = 8'h00;
endpackage : dpr_pkg

/* File: rtl/dpr_mem.sv */
// true dual-port storage array with registered read data per port
`timescale 1ns/100ps
`default_nettype none
module dpr_mem (
	// port a
	input wire logic i_clk_sys,
	input wire logic i_a_we,
	input wire logic [14:0] i_a_addr,
	input wire logic [7:0] i_a_wdata,
	output logic [7:0] o_a_rdata,
	// port b
	input wire logic i_b_we,
	input wire logic [14:0] i_b_addr,
	input wire logic [7:0] i_b_wdata,
	output logic [7:0] o_b_rdata
);
	logic [7:0] mem [0:dpr_pkg::DEPTH-1];

	// two independent ports, neither stalls the other; same-word write/read gives old data
	always_ff @(posedge i_clk_sys) begin
		if (i_a_we) begin
			mem[i_a_addr] <= i_a_wdata;
		end
		if (i_b_we) begin
			mem[i_b_addr] <= i_b_wdata;
		end
		o_a_rdata <= mem[i_a_addr];
		o_b_rdata <= mem[i_b_addr];
	end
endmodule : dpr_mem
`default_nettype wire

/* File: rtl/dpr_top.sv */
// synchronous 32k x 8 dual-port memory, two ports with burst address counters
//
// What this block does
// (R1) one shared 32768 x 8 array, two ports each with address, data and controls
// (R2) each port registers address, data and controls on its rising clock edge
// (R3) both ports access any location in one cycle, no stalling
// (R4) selected when select_low_active low and select_high_active high; else data floats
// (R5) output enable is synchronised over two stages; high forces data pins off
// (R6) each port picks flow-through or pipelined output by its own select pin
// (R7) flow-through data follows capture edge; pipelined one cycle later
// (R8) pointer_clear_n low uses address zero and clears counter, highest priority
// (R9) address_load_strobe_n low loads external address, independent of selects
// (R10) strobe and increment both high reuse previous internal address
// (R11) increment_enable_n low uses previous address plus one as new state
// (R12) counter advances whatever the selects, output enable or direction
// (R13) output_latency_select is static; high pipelined, low flow-through
// (R14) internal address is zero when cleared, external when strobed, else counter value or counter plus one
// (R15) no strobe and no increment keeps the same read data
// (R16) counter is 15 bits and wraps from top address to zero
`timescale 1ns/100ps
`default_nettype none
module dpr_top (
	// common clock and reset
	input wire logic i_clk_sys,
	input wire logic i_sys_rst,
	// left port controls
	input wire logic i_l_select_low_active,
	input wire logic i_l_select_high_active,
	input wire logic i_l_write_n,
	input wire logic i_l_output_enable_n,
	input wire logic i_l_address_load_strobe_n,
	input wire logic i_l_increment_enable_n,
	input wire logic i_l_pointer_clear_n,
	input wire logic i_l_output_latency_select,
	input wire logic [14:0] i_l_addr,
	// left port data pin
	input wire logic [7:0] i_l_data,
	output logic [7:0] o_l_data,
	output logic o_l_data_oe,
	// right port controls
	input wire logic i_r_select_low_active,
	input wire logic i_r_select_high_active,
	input wire logic i_r_write_n,
	input wire logic i_r_output_enable_n,
	input wire logic i_r_address_load_strobe_n,
	input wire logic i_r_increment_enable_n,
	input wire logic i_r_pointer_clear_n,
	input wire logic i_r_output_latency_select,
	input wire logic [14:0] i_r_addr,
	// right port data pin
	input wire logic [7:0] i_r_data,
	output logic [7:0] o_r_data,
	output logic o_r_data_oe
);
	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [1:0][14:0] cnt;     // burst counter per port
		logic [1:0] oen_s1;        // output enable sync, first stage
		logic [1:0] oen_s2;        // output enable sync, second stage
		logic [1:0] rd_ft;         // read issued last edge (flow-through stage)
		logic [1:0] rd_pp;         // read issued two edges back (pipeline stage)
		logic [1:0][7:0] pipe;     // pipelined output register
		logic [1:0][7:0] dout;     // pin data
		logic [1:0] oe;            // pin enable
	} dpr_state_t;

	dpr_state_t st_ff;
	dpr_state_t nxt_st;

	logic [1:0] sel_lo, sel_hi, wr_n, oen, ld_n, inc_n, clr_n, lat;
	logic [1:0][14:0] ext_addr;
	logic [1:0][7:0] wdata;
	logic [1:0][14:0] int_addr;
	logic [1:0] we;
	logic [1:0][7:0] rdata;

	// gather both ports into arrays so one loop serves both
	assign sel_lo = {i_r_select_low_active, i_l_select_low_active};
	assign sel_hi = {i_r_select_high_active, i_l_select_high_active};
	assign wr_n = {i_r_write_n, i_l_write_n};
	assign oen = {i_r_output_enable_n, i_l_output_enable_n};
	assign ld_n = {i_r_address_load_strobe_n, i_l_address_load_strobe_n};
	assign inc_n = {i_r_increment_enable_n, i_l_increment_enable_n};
	assign clr_n = {i_r_pointer_clear_n, i_l_pointer_clear_n};
	assign lat = {i_r_output_latency_select, i_l_output_latency_select};
	assign ext_addr = {i_r_addr, i_l_addr};
	assign wdata = {i_r_data, i_l_data};

	// ---------------------------------------------------------------
	// address selection per port
	// ---------------------------------------------------------------
	// inputs are same-domain bus master logic, so captured by the array edge directly
	always_comb begin
		for (int p = 0; p < 2; p++) begin
			if (!clr_n[p]) begin
				int_addr[p] = dpr_pkg::ADDR_ZERO; // R8
			end else if (!ld_n[p]) begin
				int_addr[p] = ext_addr[p]; // R9 R14
			end else if (!inc_n[p]) begin
				// carry out of the top bit is dropped on purpose: 7fff wraps to 0
				int_addr[p] = 15'(st_ff.cnt[p] + dpr_pkg::ADDR_ONE); // R11 R16
			end else begin
				int_addr[p] = st_ff.cnt[p]; // R10 R15
			end
			we[p] = !sel_lo[p] && sel_hi[p] && !wr_n[p]; // R4
		end
	end

	// ---------------------------------------------------------------
	// shared array
	// ---------------------------------------------------------------
	dpr_mem u_mem ( // R1 R3
		.i_clk_sys(i_clk_sys),
		.i_a_we(we[0]),
		.i_a_addr(int_addr[0]),
		.i_a_wdata(wdata[0]),
		.o_a_rdata(rdata[0]),
		.i_b_we(we[1]),
		.i_b_addr(int_addr[1]),
		.i_b_wdata(wdata[1]),
		.o_b_rdata(rdata[1])
	);

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	// the array read register is the flow-through stage; pipe adds one more cycle
	always_comb begin
		nxt_st = st_ff;
		for (int p = 0; p < 2; p++) begin
			nxt_st.cnt[p] = int_addr[p]; // R12 R2
			nxt_st.oen_s1[p] = oen[p];
			nxt_st.oen_s2[p] = st_ff.oen_s1[p];
			nxt_st.rd_ft[p] = !sel_lo[p] && sel_hi[p] && wr_n[p]; // R4 R2
			nxt_st.rd_pp[p] = st_ff.rd_ft[p];
			nxt_st.pipe[p] = rdata[p];
			// output enable is the asynchronous pin; synchronised, no clocked qualifier
			if (lat[p]) begin
				nxt_st.dout[p] = st_ff.pipe[p]; // R7 R13
				nxt_st.oe[p] = st_ff.rd_pp[p] && !st_ff.oen_s2[p]; // R5 R6
			end else begin
				nxt_st.dout[p] = rdata[p]; // R7 R13
				nxt_st.oe[p] = st_ff.rd_ft[p] && !st_ff.oen_s2[p]; // R5 R6
			end
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			st_ff <= '0;
			st_ff.dout <= {2{dpr_pkg::DATA_RST}};
			st_ff.oen_s1 <= 2'h3;
			st_ff.oen_s2 <= 2'h3;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign o_l_data = st_ff.dout[0];
	assign o_l_data_oe = st_ff.oe[0];
	assign o_r_data = st_ff.dout[1];
	assign o_r_data_oe = st_ff.oe[1];

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	property p_clear_zero;
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		!i_l_pointer_clear_n |=> (st_ff.cnt[0] == dpr_pkg::ADDR_ZERO);
	endproperty
	a_clear_zero: assert property (p_clear_zero) else $error("clear did not zero counter"); // R8

	property p_load;
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		(i_l_pointer_clear_n && !i_l_address_load_strobe_n) |=> (st_ff.cnt[0] == $past(i_l_addr));
	endproperty
	a_load: assert property (p_load) else $error("strobe did not load address"); // R9

	property p_hold;
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		(i_l_pointer_clear_n && i_l_address_load_strobe_n && i_l_increment_enable_n)
		|=> $stable(st_ff.cnt[0]);
	endproperty
	a_hold: assert property (p_hold) else $error("counter moved while idle"); // R10

	property p_inc;
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		(i_r_pointer_clear_n && i_r_address_load_strobe_n && !i_r_increment_enable_n)
		|=> (st_ff.cnt[1] == 15'($past(st_ff.cnt[1]) + dpr_pkg::ADDR_ONE));
	endproperty
	a_inc: assert property (p_inc) else $error("counter did not advance"); // R11

	property p_oe_off;
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		(i_l_output_enable_n [*3]) |=> !o_l_data_oe;
	endproperty
	a_oe_off: assert property (p_oe_off) else $error("pins driven with enable high"); // R5

	property p_desel;
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		((i_l_select_low_active || !i_l_select_high_active) && !i_l_output_latency_select)
		##1 !i_l_output_latency_select |=> !o_l_data_oe;
	endproperty
	a_desel: assert property (p_desel) else $error("deselected port drove pins"); // R4

	// pipelined port: the deselect reaches the pins one slot later
	property p_desel_pp;
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		((i_r_select_low_active || !i_r_select_high_active) && i_r_output_latency_select)
		##1 i_r_output_latency_select |=> ##1 !o_r_data_oe;
	endproperty
	a_desel_pp: assert property (p_desel_pp) else $error("deselected pipelined port drove pins"); // R4

	property p_ft_data;
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		(!i_l_output_latency_select && o_l_data_oe) |-> (o_l_data == $past(rdata[0]));
	endproperty
	a_ft_data: assert property (p_ft_data) else $error("flow-through data wrong"); // R7

	property p_pp_data;
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		(i_r_output_latency_select && $past(i_r_output_latency_select) && o_r_data_oe)
		|-> (o_r_data == $past(rdata[1], 2));
	endproperty
	a_pp_data: assert property (p_pp_data) else $error("pipelined data wrong"); // R6

endmodule : dpr_top
`default_nettype wire

/* File: tb/dpr_master.sv */
// bus master model for one memory port: owns the far end of the data pins
`timescale 1ns/100ps
`default_nettype none
module dpr_master (
	// clock
	input wire logic i_clk_sys,
	// control code {sel_lo, sel_hi, write_n, load_n, inc_n, clear_n} and write data
	input wire logic [5:0] i_ctl,
	input wire logic [7:0] i_wdata,
	// device side of the pins
	input wire logic [7:0] i_dout,
	input wire logic i_dout_oe,
	// resolved pin level
	output logic [7:0] o_pin
);
	logic [7:0] last_ff = 8'h00;
	logic drive;
	// master drives only during a selected write, never against the device
	assign drive = !i_ctl[5] && i_ctl[4] && !i_ctl[3];
	// a floating bus shows a changing level so stale data cannot pass as valid
	always_comb begin
		if (drive) begin
			o_pin = i_wdata;
		end else if (i_dout_oe) begin
			o_pin = i_dout;
		end else begin
			o_pin = ~last_ff;
		end
	end
	always_ff @(posedge i_clk_sys) last_ff <= o_pin;
endmodule : dpr_master
`default_nettype wire

/* File: tb/dpr_top_tb.sv */
// self-checking bench for the dual-port memory with burst counters
`timescale 1ns/100ps
`default_nettype none
module dpr_top_tb;
	// codes {sel_lo, sel_hi, write_n, load_n, inc_n, clear_n}
	localparam logic [5:0] RD = 6'h1b, WR = 6'h13, HOLD = 6'h1f, INC = 6'h1d, IDLE = 6'h3f;
	localparam logic [1:0] LAT = 2'h2; // left flow-through, right pipelined, static
	logic i_clk_sys = 1'b0;
	logic i_sys_rst = 1'b1;
	logic [5:0] c [2] = '{6'h3f, 6'h3f};
	logic [1:0] oe_n = 2'h0;
	logic [14:0] a [2] = '{15'h0000, 15'h0000};
	logic [7:0] wd [2] = '{8'h00, 8'h00};
	wire logic [7:0] pin [2];
	wire logic [7:0] q [2];
	wire logic [1:0] qe;
	int n_fail = 0;
	int cmp_count = 0;
	always #10 i_clk_sys = ~i_clk_sys;
	dpr_top dut (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
		.i_l_select_low_active(c[0][5]), .i_l_select_high_active(c[0][4]),
		.i_l_write_n(c[0][3]), .i_l_output_enable_n(oe_n[0]),
		.i_l_address_load_strobe_n(c[0][2]), .i_l_increment_enable_n(c[0][1]),
		.i_l_pointer_clear_n(c[0][0]), .i_l_output_latency_select(LAT[0]),
		.i_l_addr(a[0]), .i_l_data(pin[0]), .o_l_data(q[0]), .o_l_data_oe(qe[0]),
		.i_r_select_low_active(c[1][5]), .i_r_select_high_active(c[1][4]),
		.i_r_write_n(c[1][3]), .i_r_output_enable_n(oe_n[1]),
		.i_r_address_load_strobe_n(c[1][2]), .i_r_increment_enable_n(c[1][1]),
		.i_r_pointer_clear_n(c[1][0]), .i_r_output_latency_select(LAT[1]),
		.i_r_addr(a[1]), .i_r_data(pin[1]), .o_r_data(q[1]), .o_r_data_oe(qe[1]));
	dpr_master u_ml (.i_clk_sys(i_clk_sys), .i_ctl(c[0]), .i_wdata(wd[0]),
		.i_dout(q[0]), .i_dout_oe(qe[0]), .o_pin(pin[0]));
	dpr_master u_mr (.i_clk_sys(i_clk_sys), .i_ctl(c[1]), .i_wdata(wd[1]),
		.i_dout(q[1]), .i_dout_oe(qe[1]), .o_pin(pin[1]));
	// ----------------------------------------
	// drivers and checks
	// ----------------------------------------
	task automatic go(input int p, input logic [5:0] k, input logic [14:0] ad, input logic [7:0] d);
		@(posedge i_clk_sys);
		c[p] <= k;
		a[p] <= ad;
		wd[p] <= d;
	endtask : go
	task automatic ck(input int p, input int n, input logic e, input logic [7:0] d);
		repeat (n) @(posedge i_clk_sys);
		#1;
		cmp_count++;
		if (qe[p] !== e || (e && q[p] !== d)) begin
			n_fail++;
			$display("CHECK FAILED t=%0t port %0d oe %b data %h", $time, p, qe[p], q[p]);
		end
	endtask : ck
	// one access, then idle, judged in its own output slot
	task automatic acc(input int p, input logic [5:0] k, input logic [14:0] ad,
		input logic [7:0] d, input logic e);
		go(p, k, ad, d);
		go(p, IDLE, 15'h0000, 8'h00);
		ck(p, 1 + int'(LAT[p]), e, d);
	endtask : acc
	task automatic t_fill_read();
		acc(0, WR, 15'h7fff, 8'ha5, 1'b0);
		acc(1, WR, 15'h0000, 8'h5a, 1'b0);
		acc(0, WR, 15'h0001, 8'h3c, 1'b0);
		acc(1, RD, 15'h7fff, 8'ha5, 1'b1);
		acc(0, RD, 15'h0000, 8'h5a, 1'b1);
	endtask : t_fill_read
	task automatic t_select();
		acc(0, 6'h3b, 15'h0000, 8'h5a, 1'b0);
		acc(1, 6'h0b, 15'h0000, 8'h5a, 1'b0);
		acc(0, 6'h33, 15'h0000, 8'hff, 1'b0);
		acc(0, RD, 15'h0000, 8'h5a, 1'b1);
		acc(1, 6'h03, 15'h0001, 8'hff, 1'b0);
		acc(1, RD, 15'h0001, 8'h3c, 1'b1);
	endtask : t_select
	task automatic t_out_en();
		@(posedge i_clk_sys);
		oe_n[0] <= 1'b1;
		acc(0, RD, 15'h0000, 8'h5a, 1'b0);
		@(posedge i_clk_sys);
		oe_n[0] <= 1'b0;
		acc(0, RD, 15'h0001, 8'h3c, 1'b1);
	endtask : t_out_en
	task automatic t_counter();
		go(0, RD, 15'h7fff, 8'h00);
		acc(0, INC, 15'h1234, 8'h5a, 1'b1);
		go(1, RD, 15'h7fff, 8'h00);
		acc(1, HOLD, 15'h0001, 8'ha5, 1'b1);
		acc(0, 6'h1a, 15'h0001, 8'h5a, 1'b1);
		acc(0, INC, 15'h0000, 8'h3c, 1'b1);
		go(1, 6'h0b, 15'h7fff, 8'h00);
		go(1, 6'h3d, 15'h0001, 8'h00);
		acc(1, HOLD, 15'h0001, 8'h5a, 1'b1);
	endtask : t_counter
	task automatic t_both();
		@(posedge i_clk_sys);
		c[0] <= RD;
		c[1] <= RD;
		a[0] <= 15'h0001;
		a[1] <= 15'h0001;
		@(posedge i_clk_sys);
		c[0] <= IDLE;
		c[1] <= IDLE;
		fork
			ck(0, 1, 1'b1, 8'h3c);
			ck(1, 2, 1'b1, 8'h3c);
		join
		fork
			acc(0, WR, 15'h0002, 8'h11, 1'b0);
			acc(1, WR, 15'h0003, 8'h22, 1'b0);
		join
		fork
			acc(0, RD, 15'h0003, 8'h22, 1'b1);
			acc(1, RD, 15'h0002, 8'h11, 1'b1);
		join
	endtask : t_both
	// mid-run reset quiets the pins and sends both pointers back to zero
	task automatic t_reset();
		@(posedge i_clk_sys);
		i_sys_rst <= 1'b1;
		ck(0, 2, 1'b0, 8'h00);
		ck(1, 0, 1'b0, 8'h00);
		@(posedge i_clk_sys);
		i_sys_rst <= 1'b0;
		acc(0, HOLD, 15'h1234, 8'h5a, 1'b1);
		acc(1, HOLD, 15'h1234, 8'h5a, 1'b1);
	endtask : t_reset
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : report_and_stop
	// watchdog: the whole sequence needs about a hundred cycles
	initial begin
		repeat (2000) @(posedge i_clk_sys);
		n_fail++;
		report_and_stop();
	end
	initial begin
		repeat (6) @(posedge i_clk_sys);
		i_sys_rst <= 1'b0;
		t_fill_read();
		t_select();
		t_out_en();
		t_counter();
		t_both();
		t_reset();
		report_and_stop();
	end
endmodule : dpr_top_tb
`default_nettype wire
